//--- design/tcu_timer_compare.sv
`timescale 1ns/100ps
// Overview of operation
// - Compare counter with both compare values always
// - Match flag sets one timer tick later
// - Flag and mask raise compare interrupt request
// - Flag clears on service or written one
// - PWM writes buffered, otherwise compare written directly
// - Force strobe updates output only, non-PWM
// - Counter write blocks match flag and output next timer tick, not clear-on-match counter reset
// - Output state kept across mode changes
// - Output action unbuffered, applies next match
// - Nonzero action overrides port value, direction kept
// - Action zero leaves output state unchanged
// - Mode sets sequence; action sets output behaviour
// - Normal mode increments, wraps ff to 00
// - Normal mode wrap flag set at zero
// - Wrap flag clears when its interrupt serviced
// - Clear-on-match resets counter after channel A match
// - Missed top runs on through ff wrap
// - Clear-on-match action one toggles channel A
// - Clear-on-match wrap flag set passing max
// - Counter write beats clear or count
// - Clock select zero stops counter, access kept
module tcu_timer_compare
  import tcu_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Interrupt requests and service acknowledges
  output logic irq_match_a,
  output logic irq_match_b,
  output logic irq_wrap,
  input wire logic ack_match_a,
  input wire logic ack_match_b,
  input wire logic ack_wrap,
  // Compare output pins
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe_n
);

  logic [1:0] output_action_select_a_q;
  logic [1:0] output_action_select_b_q;
  logic [2:0] waveform_select_q;
  logic [2:0] clock_source_select_q;
  logic [7:0] counter_value_q;
  logic [7:0] counter_value_d;
  logic [2:0] irq_mask_q;
  logic wrap_flag_q;
  logic [1:0] port_value_q;
  logic [1:0] pin_direction_bit_q;
  logic [TCU_PRESC_W-1:0] presc_q;
  logic block_q;
  logic tick;
  logic pwm_mode;
  logic wr_ctrl_a;
  logic wr_ctrl_b;
  logic wr_counter;
  logic wr_flags;
  logic [7:0] compare_value_a;
  logic [7:0] compare_value_b;
  logic match_flag_a;
  logic match_flag_b;
  logic channel_a_output_state;
  logic channel_b_output_state;
  logic match_a;
  logic match_b;
  logic [1:0] out_sel;
  tcu_timer_ctx_t ctx;
  tcu_chan_ctl_t ctl_a;
  tcu_chan_ctl_t ctl_b;

  // Write decode
  assign wr_ctrl_a = reg_wr && reg_addr == TCU_OFS_CTRL_A;
  assign wr_ctrl_b = reg_wr && reg_addr == TCU_OFS_CTRL_B;
  assign wr_counter = reg_wr && reg_addr == TCU_OFS_COUNTER;
  assign wr_flags = reg_wr && reg_addr == TCU_OFS_FLAGS;

  // Any mode other than normal and clear-on-match is PWM
  assign pwm_mode = waveform_select_q != TCU_WAVE_NORMAL &&
                    waveform_select_q != TCU_WAVE_CLEAR_ON_MATCH;

  // Control registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      output_action_select_a_q <= TCU_RST_ACT;
      output_action_select_b_q <= TCU_RST_ACT;
      waveform_select_q <= TCU_RST_WAVE;
      clock_source_select_q <= TCU_RST_CLKSEL;
      irq_mask_q <= 3'h0;
      port_value_q <= 2'h0;
      pin_direction_bit_q <= 2'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        TCU_OFS_CTRL_A: begin
          output_action_select_a_q <= reg_wdata[TCU_ACT_A_LSB +: 2];
          output_action_select_b_q <= reg_wdata[TCU_ACT_B_LSB +: 2];
          waveform_select_q[1:0] <= reg_wdata[TCU_WAVE_LO_LSB +: 2];
        end
        TCU_OFS_CTRL_B: begin
          waveform_select_q[2] <= reg_wdata[TCU_WAVE_HI_BIT];
          clock_source_select_q <= reg_wdata[TCU_CLKSEL_LSB +: 3];
        end
        TCU_OFS_MASK: irq_mask_q <= reg_wdata[2:0];
        TCU_OFS_PORT: begin
          port_value_q <= reg_wdata[TCU_PORT_VAL_LSB +: 2];
          pin_direction_bit_q <= reg_wdata[TCU_PORT_DIR_LSB +: 2];
        end
        default: begin
        end
      endcase
    end
  end

  // Free running prescaler
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_q + 1'b1;
    end
  end

  // Timer tick from clock source select
  always_comb begin
    case (clock_source_select_q)
      3'h1: tick = 1'b1;
      3'h2: tick = &presc_q[2:0];
      3'h3: tick = &presc_q[4:0];
      3'h4: tick = &presc_q[5:0];
      3'h5: tick = &presc_q[6:0];
      3'h6: tick = &presc_q[7:0];
      3'h7: tick = &presc_q[9:0];
      default: tick = 1'b0;
    endcase
  end

  // Match blocking after a counter write, held until a tick
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      block_q <= 1'b0;
    end else if (wr_counter) begin
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  // Next count value
  always_comb begin
    counter_value_d = counter_value_q;
    if (wr_counter) begin
      counter_value_d = reg_wdata;
    end else if (tick) begin
      if (waveform_select_q == TCU_WAVE_CLEAR_ON_MATCH && match_a) begin
        counter_value_d = TCU_BOTTOM;
      end else begin
        counter_value_d = counter_value_q + 8'h01;
      end
    end
  end

  // Counter register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      counter_value_q <= TCU_RST_BYTE;
    end else begin
      counter_value_q <= counter_value_d;
    end
  end

  // Wrap flag: set passing max to zero, set wins over clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wrap_flag_q <= 1'b0;
    end else if (!wr_counter && tick && counter_value_q == TCU_MAX) begin
      wrap_flag_q <= 1'b1;
    end else if (ack_wrap || (wr_flags && reg_wdata[TCU_BIT_WRAP])) begin
      wrap_flag_q <= 1'b0;
    end
  end

  // Channel context and controls
  assign ctx = '{tick: tick, pwm_mode: pwm_mode, block: block_q,
                 counter: counter_value_q};
  assign ctl_a = '{action: output_action_select_a_q,
                   force_strobe: wr_ctrl_b && reg_wdata[TCU_FORCE_A_BIT],
                   cmp_write: reg_wr && reg_addr == TCU_OFS_CMP_A,
                   flag_clear: wr_flags && reg_wdata[TCU_BIT_MATCH_A]};
  assign ctl_b = '{action: output_action_select_b_q,
                   force_strobe: wr_ctrl_b && reg_wdata[TCU_FORCE_B_BIT],
                   cmp_write: reg_wr && reg_addr == TCU_OFS_CMP_B,
                   flag_clear: wr_flags && reg_wdata[TCU_BIT_MATCH_B]};

  // Channel A also sets the clear-on-match top
  tcu_compare_channel u_chan_a (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .ctl(ctl_a),
    .ctx(ctx),
    .wdata(reg_wdata),
    .irq_ack(ack_match_a),
    .match(match_a),
    .compare_value_q(compare_value_a),
    .match_flag_q(match_flag_a),
    .channel_output_state_q(channel_a_output_state)
  );

  // Channel B
  tcu_compare_channel u_chan_b (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .ctl(ctl_b),
    .ctx(ctx),
    .wdata(reg_wdata),
    .irq_ack(ack_match_b),
    .match(match_b),
    .compare_value_q(compare_value_b),
    .match_flag_q(match_flag_b),
    .channel_output_state_q(channel_b_output_state)
  );

  // Interrupt requests
  assign irq_match_a = match_flag_a & irq_mask_q[TCU_BIT_MATCH_A];
  assign irq_match_b = match_flag_b & irq_mask_q[TCU_BIT_MATCH_B];
  assign irq_wrap = wrap_flag_q & irq_mask_q[TCU_BIT_WRAP];

  // Pin override, direction stays with the port
  assign out_sel[0] = |output_action_select_a_q;
  assign out_sel[1] = |output_action_select_b_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_out <= 2'h0;
    end else begin
      pin_out[0] <= out_sel[0] ? channel_a_output_state : port_value_q[0];
      pin_out[1] <= out_sel[1] ? channel_b_output_state : port_value_q[1];
    end
  end
  assign pin_oe_n = ~pin_direction_bit_q;

  // Registered read data, unmapped reads give zero
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        TCU_OFS_CTRL_A: reg_rdata <= {output_action_select_a_q,
                                      output_action_select_b_q, 2'h0,
                                      waveform_select_q[1:0]};
        TCU_OFS_CTRL_B: reg_rdata <= {4'h0, waveform_select_q[2],
                                      clock_source_select_q};
        TCU_OFS_COUNTER: reg_rdata <= counter_value_q;
        TCU_OFS_CMP_A: reg_rdata <= compare_value_a;
        TCU_OFS_CMP_B: reg_rdata <= compare_value_b;
        TCU_OFS_MASK: reg_rdata <= {5'h00, irq_mask_q};
        TCU_OFS_FLAGS: reg_rdata <= {5'h00, match_flag_b, match_flag_a,
                                     wrap_flag_q};
        TCU_OFS_PORT: reg_rdata <= {4'h0, pin_direction_bit_q,
                                    port_value_q};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

//--- design/tcu_pkg.sv
package tcu_pkg;

  // Register offsets on the plain register port
  localparam logic [2:0] TCU_OFS_CTRL_A = 3'h0;
  localparam logic [2:0] TCU_OFS_CTRL_B = 3'h1;
  localparam logic [2:0] TCU_OFS_COUNTER = 3'h2;
  localparam logic [2:0] TCU_OFS_CMP_A = 3'h3;
  localparam logic [2:0] TCU_OFS_CMP_B = 3'h4;
  localparam logic [2:0] TCU_OFS_MASK = 3'h5;
  localparam logic [2:0] TCU_OFS_FLAGS = 3'h6;
  localparam logic [2:0] TCU_OFS_PORT = 3'h7;

  // Control A fields
  localparam int TCU_ACT_A_LSB = 6;
  localparam int TCU_ACT_B_LSB = 4;
  localparam int TCU_WAVE_LO_LSB = 0;
  // Control B fields
  localparam int TCU_FORCE_A_BIT = 7;
  localparam int TCU_FORCE_B_BIT = 6;
  localparam int TCU_WAVE_HI_BIT = 3;
  localparam int TCU_CLKSEL_LSB = 0;
  // Mask and flag bit positions
  localparam int TCU_BIT_WRAP = 0;
  localparam int TCU_BIT_MATCH_A = 1;
  localparam int TCU_BIT_MATCH_B = 2;
  // Port register fields
  localparam int TCU_PORT_VAL_LSB = 0;
  localparam int TCU_PORT_DIR_LSB = 2;

  // Reset values
  localparam logic [7:0] TCU_RST_BYTE = 8'h00;
  localparam logic [1:0] TCU_RST_ACT = 2'h0;
  localparam logic [2:0] TCU_RST_WAVE = 3'h0;
  localparam logic [2:0] TCU_RST_CLKSEL = 3'h0;

  // Counter landmarks
  localparam logic [7:0] TCU_BOTTOM = 8'h00;
  localparam logic [7:0] TCU_MAX = 8'hff;

  // Waveform modes
  localparam logic [2:0] TCU_WAVE_NORMAL = 3'h0;
  localparam logic [2:0] TCU_WAVE_CLEAR_ON_MATCH = 3'h2;

  // Output actions
  localparam logic [1:0] TCU_ACT_NONE = 2'h0;
  localparam logic [1:0] TCU_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] TCU_ACT_CLEAR = 2'h2;
  localparam logic [1:0] TCU_ACT_SET = 2'h3;

  // Prescaler width: largest divide is 1024
  localparam int TCU_PRESC_W = 10;

  // Per channel settings handed to a compare channel
  typedef struct packed {
    logic [1:0] action;
    logic force_strobe;
    logic cmp_write;
    logic flag_clear;
  } tcu_chan_ctl_t;

  // Timer-wide context shared by both channels
  typedef struct packed {
    logic tick;
    logic pwm_mode;
    logic block;
    logic [7:0] counter;
  } tcu_timer_ctx_t;

endpackage

//--- design/tcu_compare_channel.sv
`timescale 1ns/100ps
module tcu_compare_channel
  import tcu_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Controls
  input wire tcu_chan_ctl_t ctl,
  input wire tcu_timer_ctx_t ctx,
  input wire logic [7:0] wdata,
  input wire logic irq_ack,
  // State
  output logic match,
  output logic [7:0] compare_value_q,
  output logic match_flag_q,
  output logic channel_output_state_q
);

  logic [7:0] cmp_buffer_q;
  logic match_hit;

  // Comparator runs every cycle
  assign match = (ctx.counter == compare_value_q);
  assign match_hit = ctx.tick & match & ~ctx.block;

  // Write buffer used only in PWM modes
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cmp_buffer_q <= TCU_RST_BYTE;
    end else if (ctl.cmp_write) begin
      cmp_buffer_q <= wdata;
    end
  end

  // Active compare register: direct or copied at bottom
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      compare_value_q <= TCU_RST_BYTE;
    end else if (!ctx.pwm_mode && ctl.cmp_write) begin
      compare_value_q <= wdata;
    end else if (ctx.pwm_mode && ctx.tick && ctx.counter == TCU_BOTTOM) begin
      compare_value_q <= cmp_buffer_q;
    end
  end

  // Match flag, set wins over clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      match_flag_q <= 1'b0;
    end else if (match_hit) begin
      match_flag_q <= 1'b1;
    end else if (ctl.flag_clear || irq_ack) begin
      match_flag_q <= 1'b0;
    end
  end

  // Output state; mode changes never touch it
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      channel_output_state_q <= 1'b0;
    end else if (!ctx.pwm_mode && (match_hit || ctl.force_strobe)) begin
      // Action read live, so a new setting applies at next match
      case (ctl.action)
        TCU_ACT_TOGGLE: channel_output_state_q <= ~channel_output_state_q;
        TCU_ACT_CLEAR: channel_output_state_q <= 1'b0;
        TCU_ACT_SET: channel_output_state_q <= 1'b1;
        default: channel_output_state_q <= channel_output_state_q;
      endcase
    end else if (ctx.pwm_mode && ctl.action[1]) begin
      // Polarity: clear or set on match, opposite at bottom
      if (match_hit) begin
        channel_output_state_q <= ctl.action[0];
      end else if (ctx.tick && ctx.counter == TCU_MAX) begin
        channel_output_state_q <= ~ctl.action[0];
      end
    end
  end

endmodule

//--- dv/tcu_host_model.sv
`timescale 1ns/100ps
module tcu_host_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Service enable from the bench
  input wire logic svc_en,
  // Interrupt requests and acknowledges
  input wire logic irq_match_a,
  input wire logic irq_match_b,
  input wire logic irq_wrap,
  output logic ack_match_a,
  output logic ack_match_b,
  output logic ack_wrap,
  // Pin wire
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe_n,
  output logic [1:0] pin_level
);
  // One-cycle service pulse per raised request
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ack_match_a <= 1'b0;
      ack_match_b <= 1'b0;
      ack_wrap <= 1'b0;
    end else begin
      ack_match_a <= svc_en && irq_match_a && !ack_match_a;
      ack_match_b <= svc_en && irq_match_b && !ack_match_b;
      ack_wrap <= svc_en && irq_wrap && !ack_wrap;
    end
  end
  // Undriven pin rests at pull-up level
  assign pin_level = (pin_out & ~pin_oe_n) | pin_oe_n;
endmodule

//--- dv/tcu_timer_compare_asserts.sv
`timescale 1ns/100ps
module tcu_timer_compare_asserts
  import tcu_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Interrupts
  input wire logic irq_match_a,
  input wire logic irq_match_b,
  input wire logic irq_wrap,
  input wire logic ack_match_a,
  input wire logic ack_match_b,
  input wire logic ack_wrap,
  // Pins
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe_n
);
  logic [7:0] mask_q, cmp_a_q, port_q;
  logic [2:0] clksel_q;
  logic [1:0] act_a_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Shadow of registers the properties need
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mask_q <= 8'h00;
      cmp_a_q <= 8'h00;
      port_q <= 8'h00;
      clksel_q <= 3'h0;
      act_a_q <= 2'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        TCU_OFS_MASK: mask_q <= reg_wdata;
        TCU_OFS_CMP_A: cmp_a_q <= reg_wdata;
        TCU_OFS_PORT: port_q <= reg_wdata;
        TCU_OFS_CTRL_B: clksel_q <= reg_wdata[2:0];
        TCU_OFS_CTRL_A: act_a_q <= reg_wdata[7:6];
        default: ;
      endcase
    end
  end
  sequence s_cnt_wr;
    reg_wr && reg_addr == TCU_OFS_COUNTER && clksel_q == 3'h0;
  endsequence
  sequence s_cnt_rd;
    reg_rd && reg_addr == TCU_OFS_COUNTER && clksel_q == 3'h0;
  endsequence
  property p_rdback;
    s_cnt_wr ##1 !reg_wr ##1 s_cnt_rd |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  property p_force;
    reg_wr && reg_addr == TCU_OFS_CTRL_B && reg_wdata[TCU_FORCE_A_BIT]
      && reg_wdata[2:0] == 3'h0 && clksel_q == 3'h0 && !irq_match_a
      |=> !irq_match_a;
  endproperty
  property p_oe;
    reg_wr && reg_addr == TCU_OFS_PORT
      |=> pin_oe_n == ~$past(reg_wdata[TCU_PORT_DIR_LSB +: 2]);
  endproperty
  property p_irq_mask;
    irq_wrap |-> mask_q[TCU_BIT_WRAP];
  endproperty
  property p_ack;
    ack_wrap |=> !irq_wrap;
  endproperty
  property p_w1c;
    reg_wr && reg_addr == TCU_OFS_FLAGS && reg_wdata[TCU_BIT_MATCH_A]
      && clksel_q == 3'h0 |=> !irq_match_a;
  endproperty
  property p_port;
    $past(act_a_q) == TCU_ACT_NONE
      |-> pin_out[0] == $past(port_q[TCU_PORT_VAL_LSB]);
  endproperty
  property p_block;
    reg_wr && reg_addr == TCU_OFS_COUNTER && reg_wdata == cmp_a_q
      && mask_q[TCU_BIT_MATCH_A] && !irq_match_a |=> !irq_match_a [*2];
  endproperty
  a_rdback: assert property (p_rdback) else $error("counter readback");
  a_force: assert property (p_force) else $error("force set flag");
  a_oe: assert property (p_oe) else $error("pin enable");
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq");
  a_ack: assert property (p_ack) else $error("wrap not serviced");
  a_w1c: assert property (p_w1c) else $error("flag not cleared");
  a_port: assert property (p_port) else $error("port value lost");
  a_block: assert property (p_block) else $error("match not blocked");
endmodule
bind tcu_timer_compare tcu_timer_compare_asserts u_chk (.clk_sys, .reset_n,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq_match_a,
  .irq_match_b, .irq_wrap, .ack_match_a, .ack_match_b, .ack_wrap,
  .pin_out, .pin_oe_n);

//--- dv/test_tcu_timer_compare.sv
`timescale 1ns/100ps
module test_tcu_timer_compare import tcu_pkg::*;;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic svc_en = 1'b0;
  logic [7:0] reg_rdata;
  logic irq_match_a, irq_match_b, irq_wrap, ack_match_a, ack_match_b, ack_wrap;
  logic [1:0] pin_out, pin_oe_n, pin_level;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  tcu_timer_compare dut_u (.clk_sys, .reset_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .irq_match_a, .irq_match_b, .irq_wrap,
    .ack_match_a, .ack_match_b, .ack_wrap, .pin_out, .pin_oe_n);
  tcu_host_model host_u (.clk_sys, .reset_n, .svc_en, .irq_match_a,
    .irq_match_b, .irq_wrap, .ack_match_a, .ack_match_b, .ack_wrap,
    .pin_out, .pin_oe_n, .pin_level);
  // 25 MHz clock
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      close_out();
    end
  end
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rdchk(string what, logic [2:0] a, logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(what, d, exp);
  endtask
  task automatic t_reset();
    for (int i = 0; i < 8; i++) rdchk("reg", 3'(i), 8'h00);
    check("oe_n", {6'h00, pin_oe_n}, 8'h03);
    check("pin", {6'h00, pin_out}, 8'h00);
  endtask
  task automatic t_force();
    logic [1:0] acts [5];
    logic [4:0] pins;
    acts = '{TCU_ACT_SET, TCU_ACT_NONE, TCU_ACT_TOGGLE, TCU_ACT_CLEAR,
      TCU_ACT_TOGGLE};
    pins = 5'b10011;
    for (int i = 0; i < 5; i++) begin
      wr(TCU_OFS_CTRL_A, {acts[i], 6'h00});
      wr(TCU_OFS_CTRL_B, 8'h80);
      if (i == 0) wr(TCU_OFS_PORT, 8'h05); // State first, then drive
      idle(3);
      check("pin_a", {7'h00, pin_level[0]}, {7'h00, pins[i]});
    end
    check("oe_n", {6'h00, pin_oe_n}, 8'h02);
    rdchk("flags", TCU_OFS_FLAGS, 8'h00);
    rdchk("count", TCU_OFS_COUNTER, 8'h00);
    wr(TCU_OFS_CTRL_A, 8'h42);
    wr(TCU_OFS_CTRL_A, 8'h40);
    idle(3);
    check("pin_keep", {7'h00, pin_level[0]}, 8'h01);
  endtask
  task automatic t_block();
    wr(TCU_OFS_MASK, 8'h02);
    wr(TCU_OFS_CMP_A, 8'h05);
    rdchk("cmp_a", TCU_OFS_CMP_A, 8'h05);
    wr(TCU_OFS_COUNTER, 8'h05);
    wr(TCU_OFS_CTRL_B, 8'h01);
    idle(4);
    wr(TCU_OFS_CTRL_B, 8'h00);
    check("irq_a_blk", {7'h00, irq_match_a}, 8'h00);
    wr(TCU_OFS_COUNTER, 8'h03); // Differs from compare
    rdchk("cnt_rd", TCU_OFS_COUNTER, 8'h03);
    wr(TCU_OFS_CTRL_B, 8'h01);
    idle(6);
    wr(TCU_OFS_CTRL_B, 8'h00);
    check("irq_a", {7'h00, irq_match_a}, 8'h01);
    rdchk("flags_a", TCU_OFS_FLAGS, 8'h02);
    wr(TCU_OFS_FLAGS, 8'h02);
    rdchk("flags_clr", TCU_OFS_FLAGS, 8'h00);
  endtask
  task automatic t_chan_b();
    wr(TCU_OFS_CTRL_A, 8'h30);
    wr(TCU_OFS_MASK, 8'h04);
    wr(TCU_OFS_CMP_B, 8'h07);
    wr(TCU_OFS_PORT, 8'h0d);
    wr(TCU_OFS_COUNTER, 8'h00);
    wr(TCU_OFS_CTRL_B, 8'h01);
    idle(10);
    wr(TCU_OFS_CTRL_B, 8'h00);
    check("irq_b", {7'h00, irq_match_b}, 8'h01);
    check("pin_b", {7'h00, pin_level[1]}, 8'h01);
    check("pin_a_port", {7'h00, pin_level[0]}, 8'h01);
    svc_en <= 1'b1;
    idle(3);
    svc_en <= 1'b0;
    check("irq_b_svc", {7'h00, irq_match_b}, 8'h00);
  endtask
  task automatic t_wrap();
    logic [7:0] d;
    wr(TCU_OFS_MASK, 8'h01);
    wr(TCU_OFS_COUNTER, 8'hfd);
    wr(TCU_OFS_CTRL_B, 8'h01);
    idle(8);
    wr(TCU_OFS_CTRL_B, 8'h00);
    check("irq_wrap", {7'h00, irq_wrap}, 8'h01);
    rd(TCU_OFS_COUNTER, d);
    check("cnt_wrap", {7'h00, d > 8'h00 && d < 8'h10}, 8'h01);
    svc_en <= 1'b1;
    idle(3);
    svc_en <= 1'b0;
    check("wrap_svc", {7'h00, irq_wrap}, 8'h00);
  endtask
  task automatic t_ctc();
    int tog;
    logic last;
    logic [7:0] d;
    tog = 0;
    wr(TCU_OFS_FLAGS, 8'h07);
    wr(TCU_OFS_CTRL_A, 8'h42);
    wr(TCU_OFS_CMP_A, 8'h03);
    wr(TCU_OFS_COUNTER, 8'h00);
    wr(TCU_OFS_CTRL_B, 8'h01);
    last = pin_level[0];
    repeat (40) begin
      idle(1);
      if (pin_level[0] !== last) tog++;
      last = pin_level[0];
    end
    check("toggles", {7'h00, tog >= 9 && tog <= 11}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      rd(TCU_OFS_COUNTER, d);
      check("cnt_top", {7'h00, d <= 8'h03}, 8'h01);
    end
    wr(TCU_OFS_CTRL_B, 8'h00);
    wr(TCU_OFS_FLAGS, 8'h07);
    wr(TCU_OFS_COUNTER, 8'h0a);
    wr(TCU_OFS_CTRL_B, 8'h01);
    idle(60);
    rd(TCU_OFS_COUNTER, d);
    check("missed", {7'h00, d > 8'h0a}, 8'h01);
    rdchk("no_wrap", TCU_OFS_FLAGS, 8'h00);
    idle(220);
    rd(TCU_OFS_FLAGS, d);
    check("ctc_wrap", {7'h00, d[TCU_BIT_WRAP]}, 8'h01);
    wr(TCU_OFS_CTRL_B, 8'h00);
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    idle(1);
    t_reset();
    t_force();
    t_block();
    t_chan_b();
    t_wrap();
    t_ctc();
    close_out();
  end
endmodule
